// [supervisor_pkg.sv]
// Purpose : Shared constants and state types for the supply supervisor
// Assumes : 100 MHz system clock, comparator results arrive as logic levels
// Notes   : Long cycle counts are derived here and overridable at the top
`default_nettype none

package supervisor_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing figures in their own units
  localparam int CLK_PERIOD_NS   = 10;    // System clock period
  localparam int NS_PER_MS       = 1000000;
  localparam int RESET_PULSE_MS  = 200;   // Reset pulse length
  localparam int WDOG_TIMEOUT_MS = 1600;  // Watchdog timeout, 1.6 s

  // Derived cycle counts; both stay below 2^31 even at a 1 ns period
  localparam int RESET_PULSE_CYCLES = RESET_PULSE_MS * NS_PER_MS
                                      / CLK_PERIOD_NS;
  localparam int WDOG_TIMEOUT_CYCLES = WDOG_TIMEOUT_MS * NS_PER_MS
                                       / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Counter width, wide enough for the watchdog timeout count
  localparam int CNT_W = 28;
  typedef logic [CNT_W-1:0] cnt_t;

  // Interval timer state
  typedef struct packed {
    cnt_t count;  // Cycles run since last clear
    logic done;   // Interval elapsed, sticky until clear
  } timer_state_t;

  localparam timer_state_t TIMER_STATE_RST = '{count: '0, done: 1'b0};

  // Supervisor control state
  typedef struct packed {
    logic kick_prev;  // Kick level seen last cycle
    logic armed;      // First kick edge seen since reset released or kick float ended
    logic reset_n;    // Registered reset output, low active
    logic expired_n;  // Registered watchdog expired output, low active
    logic fail_n;     // Registered power-fail flag, low active
  } sup_state_t;

  localparam sup_state_t SUP_STATE_RST = '{kick_prev: 1'b0, armed: 1'b0,
                                           reset_n: 1'b0, expired_n: 1'b1,
                                           fail_n: 1'b1};

endpackage

`default_nettype wire

// [interval_timer.sv]
// Purpose : Run-gated interval timer with clear, saturating at a sticky done flag
// Assumes : limit_in at least one cycle
// Notes   : Done rises limit_in cycles after clear drops with run high
`timescale 1ns/1ps
`default_nettype none

module interval_timer
(
  input  wire logic                      clk_sys_in,  // System clock
  input  wire logic                      rst_n_in,    // Async reset, low
  input  wire supervisor_pkg::cnt_t      limit_in,    // Interval in cycles
  input  wire logic                      clear_in,    // Restart from zero
  input  wire logic                      run_in,      // Count this cycle
  output logic                           done_out     // Interval elapsed
);

  supervisor_pkg::timer_state_t state_q;  // Registered state
  supervisor_pkg::timer_state_t state_d;  // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Next state: clear wins, then count until the terminal value
  always_comb
  begin
    state_d = state_q;
    if (clear_in)
    begin
      // Clear restarts the interval and drops done
      state_d = supervisor_pkg::TIMER_STATE_RST;
    end
    else if (run_in && !state_q.done)
    begin
      // Saturate at done so an expiry stays visible
      if (state_q.count == limit_in - supervisor_pkg::cnt_t'(1))
      begin
        state_d.done = 1'b1;
      end
      else
      begin
        state_d.count = state_q.count + supervisor_pkg::cnt_t'(1);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= supervisor_pkg::TIMER_STATE_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign done_out = state_q.done;

endmodule // interval_timer

`default_nettype wire

// [supervisor_reset_watchdog.sv]
// Purpose : Reset generator, watchdog and power-fail flag of a supervisor
// Assumes : Comparator results and pin states arrive synchronous to clock
// Notes   : Float and drive-present inputs stand in for analog pin sensing
`timescale 1ns/1ps
`default_nettype none

module supervisor_reset_watchdog
#(
  parameter int RESET_CYCLES = supervisor_pkg::RESET_PULSE_CYCLES,
  parameter int WDOG_CYCLES  = supervisor_pkg::WDOG_TIMEOUT_CYCLES
)
(
  input  wire logic clk_sys_in,                // Time base, 100 MHz
  input  wire logic rst_n_in,                  // Async reset, low
  input  wire logic supply_low_in,             // Supply below threshold
  input  wire logic power_fail_below_in,       // Sense below reference
  input  wire logic manual_reset_request_n_in, // Manual reset level
  input  wire logic manual_reset_driven_in,    // Something drives the pin
  input  wire logic watchdog_kick_in,          // Kick level
  input  wire logic watchdog_kick_float_in,    // Kick pin three-stated
  output logic      reset_n_out,               // Reset, low active
  output logic      reset_out,                 // Reset, high active
  output logic      watchdog_expired_n_out,    // Watchdog expired, low
  output logic      power_fail_flag_n_out      // Power-fail flag, low
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  supervisor_pkg::sup_state_t state_q;  // Registered state
  supervisor_pkg::sup_state_t state_d;  // Next state
  logic manual_n_eff; // Manual reset after pull-up resolution
  logic rst_cause;   // A reset source is active now
  logic rst_done;    // Reset interval elapsed since last cause
  logic kick_edge;   // Rising or falling edge on a driven kick
  logic wd_clear;    // Watchdog timer clear
  logic wd_done;     // Watchdog interval elapsed

  ////////////////////////////////////////////////////////////////////////////
  // Source decode
  // pull-up resolves undriven pin
  assign manual_n_eff = manual_reset_driven_in ? manual_reset_request_n_in
                                               : 1'b1;
  assign rst_cause = supply_low_in | ~manual_n_eff;

  // Edge on the kick; a floating pin carries no activity
  assign kick_edge = ~watchdog_kick_float_in
                     & (watchdog_kick_in != state_q.kick_prev);

  // clear on reset, float, edge or while unarmed
  assign wd_clear = ~state_q.reset_n | watchdog_kick_float_in | kick_edge
                    | ~state_q.armed;

  ////////////////////////////////////////////////////////////////////////////
  // Reset interval timer, restarted for as long as any cause holds
  // pulse length from counted time base
  interval_timer u_reset_timer
  (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .limit_in   (supervisor_pkg::cnt_t'(RESET_CYCLES)),
    .clear_in   (rst_cause),
    .run_in     (1'b1),
    .done_out   (rst_done)
  );

  // Watchdog timer; runs only once armed by a kick edge
  // parameterised watchdog count
  interval_timer u_wdog_timer
  (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .limit_in   (supervisor_pkg::cnt_t'(WDOG_CYCLES)),
    .clear_in   (wd_clear),
    .run_in     (state_q.armed),
    .done_out   (wd_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    state_d           = state_q;
    state_d.kick_prev = watchdog_kick_in;
    if (!state_q.reset_n || watchdog_kick_float_in)
    begin
      state_d.armed = 1'b0;
    end
    else if (kick_edge)
    begin
      state_d.armed = 1'b1;
    end
    state_d.reset_n = rst_done & ~rst_cause;
    state_d.expired_n = ~(wd_done | supply_low_in);
    state_d.fail_n    = ~power_fail_below_in;
  end

  // State register; every output comes from here
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= supervisor_pkg::SUP_STATE_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reset_n_out            = state_q.reset_n;
  assign reset_out              = ~state_q.reset_n;
  assign watchdog_expired_n_out = state_q.expired_n;
  assign power_fail_flag_n_out  = state_q.fail_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  manual_trig_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !manual_n_eff |=> !reset_n_out)
    else $error("Manual reset did not assert reset");

  fail_flag_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    power_fail_below_in |=> !power_fail_flag_n_out)
    else $error("Power-fail flag not low with sense below");

  expire_out_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    wd_done |=> !watchdog_expired_n_out)
    else $error("Watchdog expiry not shown");

  float_disarm_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    watchdog_kick_float_in |=> !state_q.armed ##1 !wd_done)
    else $error("Floating kick left watchdog running");

  clear_timer_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (kick_edge || !reset_n_out) |=> !wd_done)
    else $error("Watchdog timer not cleared");

  supply_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    supply_low_in |=> !reset_n_out)
    else $error("Reset released while supply low");

  release_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(manual_n_eff) |-> !reset_n_out [*8])
    else $error("Reset ended too soon after release");

  no_wd_reset_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (rst_done && manual_n_eff && !supply_low_in) |=> reset_n_out)
    else $error("Reset asserted without a reset source");

  expire_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (wd_done && !wd_clear) |=> wd_done)
    else $error("Expiry dropped without a clear");

  expired_supply_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    supply_low_in |=> !watchdog_expired_n_out)
    else $error("Expired output high with supply low");

  expired_release_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (!supply_low_in && !wd_done) |=> watchdog_expired_n_out)
    else $error("Expired output stretched");

  reset_compl_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    reset_out == !reset_n_out)
    else $error("Reset outputs not complementary");

  arm_edge_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (kick_edge && reset_n_out) |=> state_q.armed)
    else $error("Kick edge did not arm the watchdog");

  // Any cause gives a pulse well beyond a handful of cycles
  pulse_min_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rst_cause |=> !reset_n_out [*8])
    else $error("Reset pulse shorter than minimum");

  // A brownout inside a pulse must not cut it short
  brownout_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (supply_low_in && !reset_n_out) |=> !reset_n_out [*8])
    else $error("Brownout cut the reset pulse short");

endmodule // supervisor_reset_watchdog

`default_nettype wire

// [cpu_model.sv]
// Purpose : Supervised processor and board wiring around the supervisor
// Assumes : Changes its kick output at the falling clock edge only
// Notes   : Kicks every 16 cycles, well inside the sim timeout
`timescale 1ns/1ps
`default_nettype none

module cpu_model
(
  input  wire logic clk_sys_in,     // System clock
  input  wire logic kick_en_in,     // Processor alive, services watchdog
  input  wire logic tie_en_in,      // Expired output wired to manual reset
  input  wire logic button_n_in,    // Push button level
  input  wire logic expired_n_in,   // Watchdog expired output
  input  wire logic sense_below_in, // Divider result on the board
  output var logic  kick_out,       // Kick line
  output logic      manual_n_out,   // Manual reset pin level
  output logic      sense_out       // Sense comparison, always firm
);
  logic [3:0] gap_q = 4'h0;  // Free-running cycle count, wraps every 16
  initial kick_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Toggle kick; a stalled processor simply holds its last level
  always @(negedge clk_sys_in)
  begin
    gap_q <= gap_q + 4'h1;
    if (kick_en_in && gap_q == 4'h7)
      kick_out <= ~kick_out;
  end

  // expiry reaches reset only by this wire
  assign manual_n_out = tie_en_in ? expired_n_in : button_n_in;
  assign sense_out = sense_below_in;
endmodule // cpu_model
`default_nettype wire

// [supervisor_reset_watchdog_tb.sv]
// Purpose : Self-checking bench for the supervisor
// Assumes : Short sim counts, inputs driven at falling edge
// Notes   : Window checks allow one or two cycles of register delay
`timescale 1ns/1ps
`default_nettype none

module supervisor_reset_watchdog_tb;
  localparam int RC = 20;  // Reset pulse cycles
  localparam int WC = 50;  // Watchdog timeout cycles
  logic clk_sys_in, rst_n_in, supply_low_in, pf_below, button_n;
  logic driven, kick_en, tie_en, kick_float, kick, manual_n, sense;
  logic reset_n_out, reset_out, expired_n, pf_flag_n;
  int   error_cnt = 0;  // Mismatches
  int   cmp_count = 0;  // Comparisons
  int   n;              // Cycles waited

  supervisor_reset_watchdog #(.RESET_CYCLES(RC), .WDOG_CYCLES(WC))
  u_supervisor_reset_watchdog (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .supply_low_in(supply_low_in),
    .power_fail_below_in(sense), .manual_reset_request_n_in(manual_n),
    .manual_reset_driven_in(driven), .watchdog_kick_in(kick),
    .watchdog_kick_float_in(kick_float), .reset_n_out(reset_n_out),
    .reset_out(reset_out), .watchdog_expired_n_out(expired_n),
    .power_fail_flag_n_out(pf_flag_n));
  cpu_model u_cpu_model (.clk_sys_in(clk_sys_in), .kick_en_in(kick_en),
    .tie_en_in(tie_en), .button_n_in(button_n),
    .expired_n_in(expired_n), .sense_below_in(pf_below),
    .kick_out(kick), .manual_n_out(manual_n), .sense_out(sense));

  ////////////////////////////////////////////////////////////////////////
  // Clock, 10 ns period
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys_in);
  endtask

  task automatic check(input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Both reset polarities at once
  task automatic chk_rst(input logic exp);
    check(reset_n_out, exp);
    check(reset_out, ~exp);
  endtask

  // Output being waited on: reset when pick is set, else expiry
  function automatic logic watched(input logic pick);
    return pick ? reset_n_out : expired_n;
  endfunction

  // Bounded wait; running out is a mismatch and ends the run
  task automatic wait_lvl(input logic pick, input logic v, input int lim);
    for (n = 0; n < lim && watched(pick) !== v; n++)
      cyc(1);
    if (watched(pick) !== v)
    begin
      check(watched(pick), v);
      final_report();
    end
  endtask

  task automatic final_report();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_manual();
    button_n = 1'b0;
    cyc(2);
    chk_rst(1'b0);
    button_n = 1'b1;
    cyc(RC - 2);
    chk_rst(1'b0);
    cyc(5);
    chk_rst(1'b1);
    button_n = 1'b0;
    cyc(3);
    button_n = 1'b1;
    supply_low_in = 1'b1;
    cyc(2);
    supply_low_in = 1'b0;
    cyc(RC - 2);
    chk_rst(1'b0);
    cyc(5);
    driven = 1'b0;
    button_n = 1'b0;
    cyc(5);
    chk_rst(1'b1);
    driven = 1'b1;
    button_n = 1'b1;
  endtask

  task automatic t_supply();
    supply_low_in = 1'b1;
    cyc(2);
    check(expired_n, 1'b0);
    cyc(RC + 5);
    chk_rst(1'b0);
    supply_low_in = 1'b0;
    cyc(1);
    check(expired_n, 1'b1);
    cyc(RC + 1);
    chk_rst(1'b1);
  endtask

  task automatic t_watchdog();
    pf_below = 1'b1;
    cyc(2);
    check(pf_flag_n, 1'b0);
    pf_below = 1'b0;
    kick_en = 1'b1;
    cyc(3 * WC);
    check(expired_n, 1'b1);
    kick_en = 1'b0;
    wait_lvl(1'b0, 1'b0, WC + 20);
    check(n > WC - 18, 1'b1);
    chk_rst(1'b1);
    cyc(10);
    check(expired_n, 1'b0);
    kick_en = 1'b1;
    wait_lvl(1'b0, 1'b1, 20);
    check(pf_flag_n, 1'b1);
    kick_en = 1'b0;
    tie_en = 1'b1;
    wait_lvl(1'b1, 1'b0, WC + 40);
    check(reset_out, 1'b1);
    tie_en = 1'b0;
    cyc(RC + 5);
    // Arm first, so the float really has a running timer to stop
    kick_en = 1'b1;
    cyc(20);
    kick_float = 1'b1;
    kick_en = 1'b0;
    cyc(2 * WC);
    check(expired_n, 1'b1);
    kick_float = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rst_n_in, supply_low_in, pf_below, kick_en, tie_en} = 5'h00;
    {button_n, driven, kick_float} = 3'h6;
    cyc(3);
    chk_rst(1'b0);
    check(expired_n, 1'b1);
    rst_n_in = 1'b1;
    cyc(RC - 3);
    chk_rst(1'b0);
    cyc(6);
    chk_rst(1'b1);
    t_manual();
    t_supply();
    t_watchdog();
    final_report();
  end
endmodule // supervisor_reset_watchdog_tb
`default_nettype wire
